// *** full_bridge_switch_control.sv ***
// Full-bridge switch control: mapping, tri-state, protection
`timescale 1ns/1ps
module full_bridge_switch_control #(
    parameter int TACT_CYCLES = bridge_ctrl_pkg::TACT_CYCLES,
    parameter int SC_TIMEOUT_CYCLES = bridge_ctrl_pkg::SC_TIMEOUT_CYCLES,
    parameter int DEAD_CYCLES = bridge_ctrl_pkg::DEAD_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic mode_pin,
    input wire logic leg_a_pulse_input_high,
    input wire logic leg_a_pulse_input_low,
    input wire logic leg_a_pulse_input_mid,
    input wire logic leg_b_pulse_input_high,
    input wire logic leg_b_pulse_input_low,
    input wire logic leg_b_pulse_input_mid,
    input wire logic sc_over_limit,
    input wire logic supply_lockout,
    output logic leg_a_high_switch,
    output logic leg_a_low_switch,
    output logic leg_b_high_switch,
    output logic leg_b_low_switch,
    output logic mode_independent,
    output logic sc_fault_active
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    // Every next_ value is computed in one always_comb and only
    // registered in the matching always_ff.
    logic [1:0] in_high;                 // Decoded valid-high per input
    logic [1:0] in_low;                  // Decoded valid-low per input
    logic [1:0] in_mid;                  // Decoded mid-band per input
    logic [1:0] in_tri;                  // Tri-state band per input
    logic [1:0] cmd;                     // Last valid level per input
    logic [1:0] next_cmd;
    logic [1:0] tri_off;                 // Tri-state timeout active
    logic [1:0] next_tri_off;
    logic [bridge_ctrl_pkg::TRI_W-1:0] tri_cnt [2];      // Mid-band time
    logic [bridge_ctrl_pkg::TRI_W-1:0] next_tri_cnt [2];
    logic mode_taken;                    // Mode pin already sampled
    logic next_mode_taken;
    logic mode_reg;                      // Latched arrangement
    logic next_mode_reg;
    bridge_ctrl_pkg::prot_state_e state; // Protection state
    bridge_ctrl_pkg::prot_state_e next_state;
    logic [bridge_ctrl_pkg::FCNT_W-1:0] fcnt;            // Up/down counter
    logic [bridge_ctrl_pkg::FCNT_W-1:0] next_fcnt;
    logic [bridge_ctrl_pkg::TIMER_W-1:0] ftimer;         // Restart timer
    logic [bridge_ctrl_pkg::TIMER_W-1:0] next_ftimer;
    logic sc_seen;                       // Limit hit in present cycle
    logic next_sc_seen;
    logic cmd_a_prev;                    // For cycle boundary detect
    logic next_cmd_a_prev;
    logic fault_flag;                    // Registered fault status
    logic next_fault_flag;
    logic cycle_end;                     // One switching cycle closed
    logic disable_all;                   // Lockout, protection or mode not yet latched
    logic [1:0] want [2];                // Requested state per leg

    assign in_high = {leg_b_pulse_input_high, leg_a_pulse_input_high};
    assign in_low = {leg_b_pulse_input_low, leg_a_pulse_input_low};
    assign in_mid = {leg_b_pulse_input_mid, leg_a_pulse_input_mid};
    // Mid flag, or no valid flag at all, both mean the tri-state band
    assign in_tri = in_mid | ~(in_high | in_low);

    // ------------------------------------------------------------
    // Mode latch
    // ------------------------------------------------------------
    // Sampled on the first edge after reset release, never again.
    // Re-reading the strap in service could swap the bridge wiring
    // under load; a new arrangement needs a fresh power-on reset.
    always_comb begin
        next_mode_taken = 1'b1;
        next_mode_reg = mode_reg;
        if (!mode_taken) begin
            next_mode_reg = mode_pin;
        end
    end

    // Mode registers; legs stay off until the strap has been taken
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_taken <= 1'b0;
            mode_reg <= 1'b0;
        end else begin
            mode_taken <= next_mode_taken;
            mode_reg <= next_mode_reg;
        end
    end

    // ------------------------------------------------------------
    // Per-input level and tri-state timeout
    // ------------------------------------------------------------
    // The three-level decode arrives already split into high, low
    // and mid-band flags; neither flag set is treated as mid-band.
    // The band must persist past the cycle limit before a leg is
    // released, so a slow edge through the band does not drop it.
    for (genvar i = 0; i < 2; i++) begin : g_input
        always_comb begin
            next_cmd[i] = cmd[i];
            next_tri_off[i] = tri_off[i];
            next_tri_cnt[i] = tri_cnt[i];
            if (in_high[i]) begin
                // High wins if a faulty decode sets both flags
                next_cmd[i] = 1'b1;
                next_tri_off[i] = 1'b0;
                next_tri_cnt[i] = '0;
            end else if (in_low[i]) begin
                next_cmd[i] = 1'b0;
                next_tri_off[i] = 1'b0;
                next_tri_cnt[i] = '0;
            end else if (in_tri[i]) begin
                if (tri_cnt[i] >= bridge_ctrl_pkg::TRI_W'(TACT_CYCLES)) begin
                    // Timer parks at the limit, so a long band never wraps
                    next_tri_off[i] = 1'b1;
                end else begin
                    // Command held while the timer runs
                    next_tri_cnt[i] = tri_cnt[i] + 1'b1;
                end
            end
        end

        // Level, timeout and timer; reset counts as timed out, so a
        // leg waits for a valid level after power-on.
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                cmd[i] <= 1'b0;
                tri_off[i] <= 1'b1;
                tri_cnt[i] <= '0;
            end else begin
                cmd[i] <= next_cmd[i];
                tri_off[i] <= next_tri_off[i];
                tri_cnt[i] <= next_tri_cnt[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Switching cycle boundary
    // ------------------------------------------------------------
    // A cycle closes on each rising edge of the first input's level;
    // leg B shares it, as the controller keeps both legs in step.
    // Limitation: a leg B run at its own frequency is still judged
    // against the period of input A, and a dead input A freezes the
    // counter until it toggles again.
    assign cycle_end = cmd[0] && !cmd_a_prev;

    // ------------------------------------------------------------
    // Short-circuit counter and protection state machine
    // ------------------------------------------------------------
    // In ST_RUN the counter moves only when a cycle closes and saturates at
    // both ends, so a long burst cannot wrap back to a low count.
    always_comb begin
        next_state = state;
        next_fcnt = fcnt;
        next_ftimer = ftimer;
        next_cmd_a_prev = cmd[0];
        next_fault_flag = 1'b0;
        // A hit on the closing edge counts in the closing cycle
        next_sc_seen = cycle_end ? 1'b0 : (sc_seen | sc_over_limit);
        case (state)
            bridge_ctrl_pkg::ST_RUN: begin
                if (cycle_end) begin
                    if (sc_seen || sc_over_limit) begin
                        if (fcnt != bridge_ctrl_pkg::FCNT_LIMIT) begin
                            next_fcnt = fcnt
                                + bridge_ctrl_pkg::FCNT_STEP;
                        end
                    end else if (fcnt != bridge_ctrl_pkg::FCNT_ZERO) begin
                        next_fcnt = fcnt
                            - bridge_ctrl_pkg::FCNT_STEP;
                    end
                end
                if (next_fcnt == bridge_ctrl_pkg::FCNT_LIMIT) begin
                    next_state = bridge_ctrl_pkg::ST_FAULT;
                    next_ftimer = '0;
                    next_fault_flag = 1'b1;
                end
            end
            bridge_ctrl_pkg::ST_FAULT: begin
                // Shutdown window; the timer started from zero on entry
                // and pulse input activity is ignored throughout
                next_fault_flag = 1'b1;
                next_sc_seen = 1'b0;
                if (ftimer >= bridge_ctrl_pkg::TIMER_W'(SC_TIMEOUT_CYCLES - 1))
                begin
                    next_state = bridge_ctrl_pkg::ST_RESTART;
                    next_fault_flag = 1'b0;
                end else begin
                    next_ftimer = ftimer + 1'b1;
                end
            end
            bridge_ctrl_pkg::ST_RESTART: begin
                // Count cleared here, switching resumes next cycle
                // One cycle with gates still off lets the clear land
                next_fcnt = bridge_ctrl_pkg::FCNT_ZERO;
                next_sc_seen = 1'b0;
                next_state = bridge_ctrl_pkg::ST_RUN;
            end
            default: begin
                // Illegal code: fail safe into shutdown
                next_state = bridge_ctrl_pkg::ST_FAULT;
                next_ftimer = '0;
                next_fault_flag = 1'b1;
            end
        endcase
    end

    // Protection registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= bridge_ctrl_pkg::ST_RUN;
            fcnt <= bridge_ctrl_pkg::FCNT_ZERO;
            ftimer <= '0;
            sc_seen <= 1'b0;
            cmd_a_prev <= 1'b0;
            fault_flag <= 1'b0;
        end else begin
            state <= next_state;
            fcnt <= next_fcnt;
            ftimer <= next_ftimer;
            sc_seen <= next_sc_seen;
            cmd_a_prev <= next_cmd_a_prev;
            fault_flag <= next_fault_flag;
        end
    end

    // ------------------------------------------------------------
    // Leg requests
    // ------------------------------------------------------------
    // No switching until the mode is latched, during protection, or
    // while the supply is locked out.
    assign disable_all = supply_lockout
                      || state != bridge_ctrl_pkg::ST_RUN
                      || !mode_taken;

    // Mapping per arrangement; off is the default on every path,
    // so any disable reaches the drivers within one edge
    always_comb begin
        want[0] = bridge_ctrl_pkg::LEG_OFF;
        want[1] = bridge_ctrl_pkg::LEG_OFF;
        if (!disable_all) begin
            if (!tri_off[0]) begin
                want[0] = cmd[0] ? bridge_ctrl_pkg::LEG_HIGH
                                 : bridge_ctrl_pkg::LEG_LOW;
            end
            // Independent legs: input B owns leg B
            if (mode_reg) begin
                if (!tri_off[1]) begin
                    want[1] = cmd[1] ? bridge_ctrl_pkg::LEG_HIGH
                                     : bridge_ctrl_pkg::LEG_LOW;
                end
            end else if (!tri_off[0]) begin
                // Second input unused; leg B takes the opposite state of leg A
                want[1] = cmd[0] ? bridge_ctrl_pkg::LEG_LOW
                                 : bridge_ctrl_pkg::LEG_HIGH;
            end
        end
    end

    // ------------------------------------------------------------
    // Leg drivers with dead time
    // ------------------------------------------------------------
    // Each leg has its own driver; turn-off is immediate there, and
    // only turn-on waits out the dead time.
    leg_gate_if leg_if [2] ();

    for (genvar g = 0; g < 2; g++) begin : g_leg
        // Request per leg handed over through the interface
        assign leg_if[g].want = want[g];
        leg_gate_driver #(
            .DEAD(DEAD_CYCLES)
        ) u_drv (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .gate(leg_if[g])
        );
    end

    // Gate outputs straight from the driver registers
    // Mode and fault flags are registers too, no logic on the way
    assign leg_a_high_switch = leg_if[0].high_on;
    assign leg_a_low_switch = leg_if[0].low_on;
    assign leg_b_high_switch = leg_if[1].high_on;
    assign leg_b_low_switch = leg_if[1].low_on;
    assign mode_independent = mode_reg;
    assign sc_fault_active = fault_flag;

endmodule : full_bridge_switch_control

// *** bridge_ctrl_pkg.sv ***
// Constants shared by the full-bridge switch control design
package bridge_ctrl_pkg;

    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;      // System clock rate
    localparam int CLK_PERIOD_PS = 25_000;   // 25 ns period

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int TACT_NS = 100;            // Tri-state activation time
    // Least time: round up to whole cycles, at least one
    localparam int TACT_CYCLES_RAW =
        (TACT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TACT_CYCLES = (TACT_CYCLES_RAW < 1) ? 1 : TACT_CYCLES_RAW;
    localparam int SC_TIMEOUT_MS = 20;       // Short-circuit restart delay
    localparam int SC_TIMEOUT_CYCLES = SC_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int DEAD_CYCLES = 4;          // Leg dead time, in cycles

    // ------------------------------------------------------------
    // Widths and fault counter
    // ------------------------------------------------------------
    localparam int TRI_W = 8;                // Tri-state timer width
    localparam int DEAD_W = 8;               // Dead-time counter width
    localparam int TIMER_W = 20;             // Fault timer width
    localparam int FCNT_W = 3;               // Fault counter width
    localparam logic [FCNT_W-1:0] FCNT_ZERO = 3'h0;
    localparam logic [FCNT_W-1:0] FCNT_STEP = 3'h1;
    localparam logic [FCNT_W-1:0] FCNT_LIMIT = 3'h7;

    // ------------------------------------------------------------
    // Leg gate codes {high, low}
    // ------------------------------------------------------------
    localparam logic [1:0] LEG_OFF = 2'h0;
    localparam logic [1:0] LEG_LOW = 2'h1;
    localparam logic [1:0] LEG_HIGH = 2'h2;

    // ------------------------------------------------------------
    // Protection state machine, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN     = 3'h1,
        ST_FAULT   = 3'h2,
        ST_RESTART = 3'h4
    } prot_state_e;

endpackage : bridge_ctrl_pkg

// *** leg_gate_if.sv ***
// Gate request and gate drive of one bridge leg
`timescale 1ns/1ps
interface leg_gate_if;
    logic [1:0] want;      // Requested leg state {high, low}
    logic high_on;         // High switch gate, registered
    logic low_on;          // Low switch gate, registered

    modport ctrl (output want, input high_on, input low_on);
    modport drv (input want, output high_on, output low_on);
endinterface : leg_gate_if

// *** leg_gate_driver.sv ***
// Dead-time gate driver of one bridge leg
`timescale 1ns/1ps
module leg_gate_driver #(
    parameter int DEAD = bridge_ctrl_pkg::DEAD_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    leg_gate_if.drv gate
);

    logic [1:0] cur;                                 // Present gate state
    logic [1:0] next_cur;
    logic [bridge_ctrl_pkg::DEAD_W-1:0] dcnt;        // Cycles spent off
    logic [bridge_ctrl_pkg::DEAD_W-1:0] next_dcnt;
    logic dead_done;                                 // Dead time elapsed

    assign dead_done = (dcnt >= bridge_ctrl_pkg::DEAD_W'(DEAD));

    // ------------------------------------------------------------
    // Next gate state
    // ------------------------------------------------------------
    // Any change passes through all-off; turning on waits the dead
    // time, turning off is immediate so faults act at once.
    always_comb begin
        next_cur = cur;
        next_dcnt = dcnt;
        if (cur != bridge_ctrl_pkg::LEG_OFF && gate.want != cur) begin
            next_cur = bridge_ctrl_pkg::LEG_OFF;
            next_dcnt = '0;
        end else if (cur == bridge_ctrl_pkg::LEG_OFF) begin
            if (!dead_done) begin
                next_dcnt = dcnt + 1'b1;
            end else if (gate.want != bridge_ctrl_pkg::LEG_OFF) begin
                next_cur = gate.want;
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cur <= bridge_ctrl_pkg::LEG_OFF;
            dcnt <= '0;
        end else begin
            cur <= next_cur;
            dcnt <= next_dcnt;
        end
    end

    // Both gates come from one code, so they can never both be on
    assign gate.high_on = cur[1];
    assign gate.low_on = cur[0];

endmodule : leg_gate_driver

// *** full_bridge_switch_control_properties.sv ***
// Concurrent checks on the full-bridge switch control ports
`timescale 1ns/1ps
module full_bridge_switch_control_properties #(
    parameter int TACT_CYCLES = 4,
    parameter int SC_TIMEOUT_CYCLES = 50
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic leg_a_pulse_input_high,
    input wire logic leg_a_pulse_input_low,
    input wire logic leg_a_pulse_input_mid,
    input wire logic supply_lockout,
    input wire logic leg_a_high_switch,
    input wire logic leg_a_low_switch,
    input wire logic leg_b_high_switch,
    input wire logic leg_b_low_switch,
    input wire logic mode_independent,
    input wire logic sc_fault_active
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic [7:0] mid_cnt; // Consecutive mid-band samples on input A
    logic [19:0] flen; // Cycles spent in the current fault window
    logic a_mid; // Input A in the tri-state band only
    logic all_off; // No gate driven at all
    assign a_mid = leg_a_pulse_input_mid && !leg_a_pulse_input_high
        && !leg_a_pulse_input_low;
    assign all_off = !(leg_a_high_switch || leg_a_low_switch
        || leg_b_high_switch || leg_b_low_switch);
    // The mid-band counter saturates so a long idle band cannot wrap
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mid_cnt <= 8'h00;
            flen <= 20'h00000;
        end else begin
            mid_cnt <= a_mid ? mid_cnt + {7'h00, mid_cnt != 8'hFF} : 8'h00;
            flen <= sc_fault_active ? flen + 20'h00001 : 20'h00000;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_no_overlap_a: assert property (
        !(leg_a_high_switch && leg_a_low_switch))
        else $error("leg A gates on together");
    a_no_overlap_b: assert property (
        !(leg_b_high_switch && leg_b_low_switch))
        else $error("leg B gates on together");
    a_dead_time_a: assert property (
        $fell(leg_a_high_switch) |-> (!leg_a_low_switch)[*4])
        else $error("leg A dead time short");
    a_lockout_all_off: assert property (
        supply_lockout[*2] |=> all_off)
        else $error("gate on during supply lockout");
    a_fault_all_off: assert property (
        sc_fault_active |=> all_off)
        else $error("gate on during fault shutdown");
    a_fault_window_len: assert property (
        $fell(sc_fault_active) |-> flen == SC_TIMEOUT_CYCLES)
        else $error("fault window length wrong");
    // The mode register loads on the first edge after release, so
    // stability is judged only from the third edge on
    a_mode_frozen: assert property (
        $past(resetn, 2) |-> $stable(mode_independent))
        else $error("latched mode changed");
    a_diag_pairing: assert property (
        !mode_independent |-> leg_b_high_switch == leg_a_low_switch
        && leg_b_low_switch == leg_a_high_switch)
        else $error("diagonal pairing broken");
    a_tri_hold: assert property (
        mid_cnt >= 1 && mid_cnt < TACT_CYCLES
        && !sc_fault_active && !supply_lockout
        |=> $stable({leg_a_high_switch, leg_a_low_switch}))
        else $error("leg A changed on entering mid band");
    a_tri_off: assert property (
        mid_cnt >= TACT_CYCLES + 4 |->
        !leg_a_high_switch && !leg_a_low_switch)
        else $error("leg A still on after tri-state timeout");
    c_fault: cover property ($rose(sc_fault_active));
    c_tri_timeout: cover property (mid_cnt == TACT_CYCLES + 4);
    c_lockout: cover property (supply_lockout[*2]);
endmodule : full_bridge_switch_control_properties

bind full_bridge_switch_control full_bridge_switch_control_properties #(
    .TACT_CYCLES(TACT_CYCLES), .SC_TIMEOUT_CYCLES(SC_TIMEOUT_CYCLES)
) u_props (.clk_sys(clk_sys), .resetn(resetn),
    .leg_a_pulse_input_high(leg_a_pulse_input_high),
    .leg_a_pulse_input_low(leg_a_pulse_input_low),
    .leg_a_pulse_input_mid(leg_a_pulse_input_mid),
    .supply_lockout(supply_lockout), .leg_a_high_switch(leg_a_high_switch),
    .leg_a_low_switch(leg_a_low_switch),
    .leg_b_high_switch(leg_b_high_switch),
    .leg_b_low_switch(leg_b_low_switch), .mode_independent(mode_independent),
    .sc_fault_active(sc_fault_active));

// *** pulse_controller_model.sv ***
// Transmitter controller model driving the decoded pulse inputs
`timescale 1ns/1ps
module pulse_controller_model (
    input wire logic [1:0] level_a,
    input wire logic [1:0] level_b,
    input wire logic comp,
    output logic a_high,
    output logic a_low,
    output logic a_mid,
    output logic b_high,
    output logic b_low,
    output logic b_mid
);
    // ----------------------------------------
    // Level codes: 0 low, 1 high, 2 mid band
    // ----------------------------------------
    logic [1:0] eff_b; // Level really driven on input B
    // Complementary drive follows A only while A is valid
    always_comb begin
        if (comp && level_a != 2'h2) begin
            eff_b = {1'b0, ~level_a[0]};
        end else begin
            eff_b = level_b;
        end
    end
    // One indication at a time, as a band decoder gives
    assign a_high = level_a == 2'h1;
    assign a_low = level_a == 2'h0;
    assign a_mid = level_a == 2'h2;
    assign b_high = eff_b == 2'h1;
    assign b_low = eff_b == 2'h0;
    assign b_mid = eff_b == 2'h2;
endmodule : pulse_controller_model

// *** full_bridge_switch_control_tb.sv ***
// Self-checking bench of the full-bridge switch control
`timescale 1ns/1ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin \
    n_errors++; $display("wrong value at %0t: %h / %h", $time, act, exp); \
    end end
module full_bridge_switch_control_tb;
    localparam int SC = 50; // Shortened restart delay
    logic clk_sys = 0, resetn = 0, mode_pin = 1, comp = 0;
    logic sc_over_limit = 0, supply_lockout = 0;
    logic [1:0] level_a = 2'h0, level_b = 2'h0; // Partner level codes
    wire ah, al, am, bh, bl, bm; // Decoded pulse inputs
    wire qah, qal, qbh, qbl, mode_ind, fault; // Block outputs
    wire [3:0] gates; // {A high, A low, B high, B low}
    int n_errors = 0, comparisons = 0;
    assign gates = {qah, qal, qbh, qbl};
    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;
    pulse_controller_model u_ctrl (.level_a(level_a), .level_b(level_b),
        .comp(comp), .a_high(ah), .a_low(al), .a_mid(am),
        .b_high(bh), .b_low(bl), .b_mid(bm));
    full_bridge_switch_control #(.SC_TIMEOUT_CYCLES(SC)) u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .mode_pin(mode_pin),
        .leg_a_pulse_input_high(ah), .leg_a_pulse_input_low(al),
        .leg_a_pulse_input_mid(am), .leg_b_pulse_input_high(bh),
        .leg_b_pulse_input_low(bl), .leg_b_pulse_input_mid(bm),
        .sc_over_limit(sc_over_limit), .supply_lockout(supply_lockout),
        .leg_a_high_switch(qah), .leg_a_low_switch(qal),
        .leg_b_high_switch(qbh), .leg_b_low_switch(qbl),
        .mode_independent(mode_ind), .sc_fault_active(fault));
    // Inputs move 1 ns after the rising edge
    task step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    // Power-on reset, then the strap pin flips and must be ignored
    task do_reset(input logic m);
        resetn = 0;
        mode_pin = m;
        level_a = 2'h0;
        level_b = 2'h1;
        comp = 0;
        sc_over_limit = 0;
        supply_lockout = 0;
        step(2);
        resetn = 1;
        step(2);
        `CHK(mode_ind, m)
        mode_pin = ~m;
        step(12);
        `CHK(mode_ind, m)
    endtask : do_reset
    // Each input owns its leg; dead time on a flip; A alone times out
    task t_indep;
        do_reset(1'b1);
        `CHK(gates, 4'h6)
        level_a = 2'h1;
        level_b = 2'h0;
        step(3);
        `CHK(gates[3:2], 2'h0)
        step(10);
        `CHK(gates, 4'h9)
        level_b = 2'h1;
        step(12);
        `CHK(gates, 4'hA)
        level_a = 2'h2;
        step(2);
        `CHK(gates, 4'hA)
        step(10);
        `CHK(gates, 4'h2)
    endtask : t_indep
    // Diagonal pairs from A only, B ignored, tri-state timeout too
    task t_diag;
        do_reset(1'b0);
        level_a = 2'h1;
        step(12);
        `CHK(gates, 4'h9)
        level_b = 2'h0;
        step(12);
        `CHK(gates, 4'h9)
        level_b = 2'h2;
        step(12);
        `CHK(gates, 4'h9)
        level_a = 2'h0;
        step(12);
        `CHK(gates, 4'h6)
        level_a = 2'h2;
        step(2);
        `CHK(gates, 4'h6)
        step(10);
        `CHK(gates, 4'h0)
        step(20);
        `CHK(gates, 4'h0)
        level_a = 2'h1;
        step(12);
        `CHK(gates, 4'h9)
    endtask : t_diag
    // One switching period closed by a rising edge of input A
    task sw_cycle(input logic over);
        sc_over_limit = over;
        level_a = 2'h0;
        step(10);
        sc_over_limit = 0;
        level_a = 2'h1;
        step(10);
    endtask : sw_cycle
    // Floor at zero, count to seven, shutdown, restart with clear count
    task t_short;
        do_reset(1'b1);
        comp = 1;
        repeat (2) sw_cycle(1'b0);
        repeat (6) sw_cycle(1'b1);
        `CHK(fault, 1'b0)
        sw_cycle(1'b0);
        sw_cycle(1'b1);
        `CHK(fault, 1'b0)
        sw_cycle(1'b1);
        `CHK(fault, 1'b1)
        `CHK(gates, 4'h0)
        step(SC + 12);
        `CHK(fault, 1'b0)
        `CHK(gates, 4'h9)
        sw_cycle(1'b1);
        `CHK(fault, 1'b0)
    endtask : t_short
    // Supply lockout drops every gate, release brings them back
    task t_lockout;
        supply_lockout = 1;
        step(3);
        `CHK(gates, 4'h0)
        supply_lockout = 0;
        step(12);
        `CHK(gates, 4'h9)
    endtask : t_lockout
    // Verdict and end of run
    task wrap_up;
        if (n_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        t_indep();
        t_diag();
        t_short();
        t_lockout();
        wrap_up();
    end
    // Watchdog well beyond the expected run of about 500 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        wrap_up();
    end
endmodule : full_bridge_switch_control_tb
